// ==== regfile_pkg.sv ====
package regfile_pkg;

   // ------------------------------------------------------------
   // Storage counts and widths
   // ------------------------------------------------------------
   localparam int unsigned NUM_GP   = 8;   // General-purpose registers
   localparam int unsigned NUM_SEG  = 6;   // Segment selectors
   localparam int unsigned NUM_CTRL = 5;   // Control registers
   localparam int unsigned NUM_FPR  = 8;   // Float / multimedia registers
   localparam int unsigned GP_W     = 32;  // Full register width
   localparam int unsigned HALF_W   = 16;  // Low-half view width
   localparam int unsigned BYTE_W   = 8;   // Byte view width
   localparam int unsigned SEG_W    = 16;  // Segment selector width
   localparam int unsigned FPR_W    = 80;  // Float data register width
   localparam int unsigned MM_W     = 64;  // Multimedia view width
   localparam int unsigned ADDR_W   = 9;   // Decoded byte address bits

   // ------------------------------------------------------------
   // Float register field layout
   // ------------------------------------------------------------
   localparam int unsigned FPR_SIGN_BIT = 79;  // Sign
   localparam int unsigned FPR_EXP_HI   = 78;  // Exponent top
   localparam int unsigned FPR_EXP_LO   = 64;  // Exponent bottom
   localparam int unsigned FPR_SIG_HI   = 63;  // Significand top
   localparam int unsigned TAG_W        = 2;   // Tag field per register

   // ------------------------------------------------------------
   // Address regions, compared against slices of the byte address
   // ------------------------------------------------------------
   localparam logic [3:0] SEL_GP_FULL = 4'h0;  // 0x000 addr[8:5]
   localparam logic [3:0] SEL_GP_HALF = 4'h1;  // 0x020 addr[8:5]
   localparam logic [4:0] SEL_GP_LOB  = 5'h04; // 0x040 addr[8:4]
   localparam logic [4:0] SEL_GP_HIB  = 5'h05; // 0x050 addr[8:4]
   localparam logic [3:0] SEL_SEG     = 4'h3;  // 0x060 addr[8:5]
   localparam logic [8:0] ADDR_IP     = 9'h078; // Instruction pointer
   localparam logic [8:0] ADDR_MODE   = 9'h07C; // Operand mode
   localparam logic [8:0] ADDR_FLAGS  = 9'h080; // Flags register
   localparam logic [8:0] ADDR_FSW    = 9'h084; // Float status word
   localparam logic [8:0] ADDR_FCW    = 9'h088; // Float control word
   localparam logic [8:0] ADDR_FTW    = 9'h08C; // Float tag word
   localparam logic [8:0] ADDR_HOLE   = 9'h090; // Unmapped word
   localparam logic [3:0] SEL_CTRL    = 4'h5;  // 0x0A0 addr[8:5]
   localparam logic [1:0] SEL_FPR     = 2'h2;  // 0x100 addr[8:7]
   localparam logic [2:0] SEL_MM      = 3'h6;  // 0x180 addr[8:6]
   localparam logic [1:0] FPR_WORD_HI = 2'h2;  // Sign and exponent word
   localparam int unsigned PAGE_DIR_IDX = 3;   // Page directory control

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [31:0] RST_WORD   = 32'h0000_0000;
   localparam logic        RST_OP32   = 1'b1;  // Start in 32-bit mode

   // ------------------------------------------------------------
   // Bus encodings
   // ------------------------------------------------------------
   localparam logic HRESP_OKAY = 1'b0;
   localparam int unsigned HTRANS_ACTIVE_BIT = 1; // NONSEQ or SEQ

endpackage

// ==== cpu_architectural_register_file.sv ====
`timescale 1ns/1ps
// Overview of operation
// (RULE1) Eight 32-bit general-purpose registers
// (RULE2) Four registers have overlaid 16/8-bit views
// (RULE3) Half is low 16; bytes split it
// (RULE4) Index and pointer registers: half view only
// (RULE5) Six 16-bit segment selector registers
// (RULE6) Instruction pointer moves only by transfers; here sequential steps also advance it
// (RULE7) Eight 80-bit floats, status, control, tag
// (RULE8) Sign 79, exponent 78:64, significand 63:0
// (RULE9) Status word is 16 bits
// (RULE10) Tag word: register seven highest field
// (RULE11) Eight 64-bit multimedia registers, numbered 0-7
// (RULE12) Multimedia storage shared with float registers
// (RULE13) Float registers hold four data formats
// (RULE14) General registers carry byte to quadword; here they are 32 bits wide
// (RULE15) Flags: system, direction and status classes
// (RULE16) Five control registers, one page directory
// (RULE17) Software leaves reserved fields untouched
// (RULE18) Multimedia n is significand of float n
// (RULE19) Narrow writes keep the other bits
module cpu_architectural_register_file (
   input  wire logic        hclk,               // Processor clock
   input  wire logic        hresetn,            // Async reset, low
   input  wire logic        hsel,               // Slave select
   input  wire logic [31:0] haddr,              // Byte address
   input  wire logic [1:0]  htrans,             // Transfer type
   input  wire logic        hwrite,             // Write strobe
   input  wire logic [2:0]  hsize,              // Word only
   input  wire logic        hready,             // Bus ready
   input  wire logic [31:0] hwdata,             // Write data
   output logic             hreadyout,          // Slave ready
   output logic             hresp,              // Always OKAY
   output logic      [31:0] hrdata,             // Read data
   input  wire logic        xfer_valid,         // Jump, call, return
   input  wire logic [31:0] xfer_target,        // Transfer target
   input  wire logic        step_valid,         // Sequential advance
   input  wire logic [3:0]  step_len,           // Instruction length
   output logic      [31:0] instruction_pointer, // Current pointer
   output logic             operand_32,         // Operand mode
   output logic      [31:0] flags_reg,          // Flags to pipeline
   output logic      [31:0] page_directory_control // Paging base
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [regfile_pkg::NUM_GP-1:0][regfile_pkg::GP_W-1:0]    gp;
      logic [regfile_pkg::NUM_SEG-1:0][regfile_pkg::SEG_W-1:0]  seg;
      logic [regfile_pkg::GP_W-1:0]                             ip;
      logic                                                     op32;
      logic [regfile_pkg::GP_W-1:0]                             flags;
      logic [regfile_pkg::HALF_W-1:0]                           fsw;
      logic [regfile_pkg::HALF_W-1:0]                           fcw;
      logic [regfile_pkg::HALF_W-1:0]                           ftw;
      logic [regfile_pkg::NUM_CTRL-1:0][regfile_pkg::GP_W-1:0]  ctrl;
      logic [regfile_pkg::NUM_FPR-1:0][regfile_pkg::FPR_W-1:0]  fpr;
      logic                                                     wr_pend;
      logic                                                     rd_pend;
      logic [regfile_pkg::ADDR_W-1:0]                           addr;
      logic [regfile_pkg::GP_W-1:0]                             rdata;
   } state_type;

   state_type s;       // Registered state
   state_type next_s;  // Next state

   logic                           take;      // Address phase accepted
   logic                           in_range;  // Upper address bits clear
   logic [regfile_pkg::ADDR_W-1:0] a;         // Latched address alias
   logic [31:0]                    rd_word;   // Decoded read value

   assign a        = s.addr;
   assign in_range = (haddr[31:regfile_pkg::ADDR_W] == '0);
   assign take     = hsel & htrans[regfile_pkg::HTRANS_ACTIVE_BIT] & hready;

   // ------------------------------------------------------------
   // Read decode of the latched address
   // ------------------------------------------------------------
   // Unmapped words and reserved upper bits read as zero
   always_comb begin
      rd_word = regfile_pkg::RST_WORD;
      if (a[8:5] == regfile_pkg::SEL_GP_FULL) begin
         rd_word = s.gp[a[4:2]];                              // RULE1
      end else if (a[8:5] == regfile_pkg::SEL_GP_HALF) begin
         rd_word = {16'h0000, s.gp[a[4:2]][15:0]};            // RULE4 RULE14
      end else if (a[8:4] == regfile_pkg::SEL_GP_LOB) begin
         rd_word = {24'h000000, s.gp[{1'b0, a[3:2]}][7:0]};   // RULE3
      end else if (a[8:4] == regfile_pkg::SEL_GP_HIB) begin
         rd_word = {24'h000000, s.gp[{1'b0, a[3:2]}][15:8]};  // RULE3
      end else if (a[8:5] == regfile_pkg::SEL_SEG &&
                   a[4:2] < 3'(regfile_pkg::NUM_SEG)) begin
         // Top two words of this region are pointer and mode
         rd_word = {16'h0000, s.seg[a[4:2]]};                 // RULE5
      end else if (a == regfile_pkg::ADDR_IP) begin
         // Visible here; the pipeline moves it, a 16-bit mode write clears its top half
         rd_word = s.ip;
      end else if (a == regfile_pkg::ADDR_MODE) begin
         // Set means 32-bit operands
         rd_word = {31'h0000_0000, s.op32};
      end else if (a == regfile_pkg::ADDR_FLAGS) begin
         // All three flag classes in one word
         rd_word = s.flags;                                   // RULE15
      end else if (a == regfile_pkg::ADDR_FSW) begin
         // Plain storage; no float unit behind it
         rd_word = {16'h0000, s.fsw};                         // RULE9
      end else if (a == regfile_pkg::ADDR_FCW) begin
         rd_word = {16'h0000, s.fcw};                         // RULE7
      end else if (a == regfile_pkg::ADDR_FTW) begin
         // Two tag bits per register, seven on top
         rd_word = {16'h0000, s.ftw};                         // RULE10
      end else if (a[8:5] == regfile_pkg::SEL_CTRL) begin
         // Five words; the rest of the region reads zero
         if (a[4:2] < 3'(regfile_pkg::NUM_CTRL)) begin
            rd_word = s.ctrl[a[4:2]];                         // RULE16
         end
      end else if (a[8:7] == regfile_pkg::SEL_FPR) begin
         // Four words per float register, the last one reserved
         unique case (a[3:2])
            2'h0: rd_word = s.fpr[a[6:4]][31:0];              // RULE8
            2'h1: rd_word = s.fpr[a[6:4]][63:32];
            2'h2: rd_word = {16'h0000, s.fpr[a[6:4]][79:64]};
            2'h3: rd_word = regfile_pkg::RST_WORD;
         endcase
      end else if (a[8:6] == regfile_pkg::SEL_MM) begin
         // Same storage as the float significand
         rd_word = a[2] ? s.fpr[a[5:3]][63:32]                // RULE18
                        : s.fpr[a[5:3]][31:0];                // RULE11
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   // Writes commit in the data phase with hwdata; reads sample one
   // cycle later so a write just before them is already visible.
   always_comb begin
      next_s         = s;
      next_s.rd_pend = 1'b0;
      next_s.wr_pend = 1'b0;
      // Read answer registered during the wait cycle
      if (s.rd_pend) begin
         next_s.rdata = rd_word;
      end
      // Data phase of a write
      if (s.wr_pend) begin
         if (a[8:5] == regfile_pkg::SEL_GP_FULL) begin
            next_s.gp[a[4:2]] = hwdata;                       // RULE1
         end else if (a[8:5] == regfile_pkg::SEL_GP_HALF) begin
            // Only the low half changes
            next_s.gp[a[4:2]][15:0] = hwdata[15:0];           // RULE19
         end else if (a[8:4] == regfile_pkg::SEL_GP_LOB) begin
            // Byte views exist only for the first four registers
            next_s.gp[{1'b0, a[3:2]}][7:0] = hwdata[7:0];     // RULE2
         end else if (a[8:4] == regfile_pkg::SEL_GP_HIB) begin
            next_s.gp[{1'b0, a[3:2]}][15:8] = hwdata[7:0];    // RULE3
         end else if (a[8:5] == regfile_pkg::SEL_SEG &&
                      a[4:2] < 3'(regfile_pkg::NUM_SEG)) begin
            // Pointer and mode words share this region
            next_s.seg[a[4:2]] = hwdata[15:0];                // RULE5
         end else if (a == regfile_pkg::ADDR_MODE) begin
            // Takes effect from the next cycle on
            next_s.op32 = hwdata[0];
         end else if (a == regfile_pkg::ADDR_FLAGS) begin
            // Software owns every flag bit here
            next_s.flags = hwdata;                            // RULE15
         end else if (a == regfile_pkg::ADDR_FSW) begin
            // No float unit updates it behind software
            next_s.fsw = hwdata[15:0];                        // RULE9
         end else if (a == regfile_pkg::ADDR_FCW) begin
            next_s.fcw = hwdata[15:0];                        // RULE7
         end else if (a == regfile_pkg::ADDR_FTW) begin
            next_s.ftw = hwdata[15:0];                        // RULE10
         end else if (a[8:5] == regfile_pkg::SEL_CTRL) begin
            if (a[4:2] < 3'(regfile_pkg::NUM_CTRL)) begin
               next_s.ctrl[a[4:2]] = hwdata;                  // RULE16
            end
         end else if (a[8:7] == regfile_pkg::SEL_FPR) begin
            // Raw 80-bit container for every stored format
            unique case (a[3:2])
               2'h0: next_s.fpr[a[6:4]][31:0]  = hwdata;      // RULE13
               2'h1: next_s.fpr[a[6:4]][63:32] = hwdata;
               2'h2: next_s.fpr[a[6:4]][79:64] = hwdata[15:0]; // RULE8
               2'h3: ;                                  // Reserved word
            endcase
         end else if (a[8:6] == regfile_pkg::SEL_MM) begin
            // Writing a multimedia view leaves sign and exponent alone
            if (a[2]) begin
               next_s.fpr[a[5:3]][63:32] = hwdata;            // RULE12
            end else begin
               next_s.fpr[a[5:3]][31:0] = hwdata;             // RULE18
            end
         end
         // Instruction pointer address is read-only: write dropped
      end
      // Pointer moves by transfer first, else by sequential step
      if (xfer_valid) begin
         // A transfer overrides a step in the same cycle
         next_s.ip = xfer_target;                             // RULE6
      end else if (step_valid) begin
         // Length is zero-extended before the add
         next_s.ip = s.ip + {28'h000_0000, step_len};         // RULE6
      end
      // In 16-bit mode the pointer wraps inside the low half
      if (!next_s.op32) begin
         next_s.ip[31:16] = 16'h0000;                         // RULE6
      end
      // New address phase
      if (take) begin
         next_s.addr    = haddr[regfile_pkg::ADDR_W-1:0];
         // Out-of-range addresses alias to an unmapped word, so a
         // read answers zero instead of a live register
         if (!in_range) begin
            next_s.addr = regfile_pkg::ADDR_HOLE;
         end
         next_s.wr_pend = hwrite & in_range;
         next_s.rd_pend = ~hwrite;
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         // All clear except the operand mode
         s      <= '0;
         s.op32 <= regfile_pkg::RST_OP32;
      end else begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // One wait state on reads, none on writes
   assign hreadyout              = ~s.rd_pend;
   assign hresp                  = regfile_pkg::HRESP_OKAY;
   assign hrdata                 = s.rdata;
   assign instruction_pointer    = s.ip;
   assign operand_32             = s.op32;
   assign flags_reg              = s.flags;
   // Control register three holds the page directory
   assign page_directory_control = s.ctrl[regfile_pkg::PAGE_DIR_IDX];

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Data-phase decodes of the latched address
   logic is_full;  // Latched address hits a full view
   logic is_half;  // Low-half view
   logic is_hib;   // High-byte view
   logic is_lob;   // Low-byte view
   logic is_seg;   // Segment selector
   logic is_fhi;   // Float sign and exponent word
   logic is_mm;    // Multimedia view
   assign is_full = s.wr_pend & (a[8:5] == regfile_pkg::SEL_GP_FULL);
   assign is_half = s.wr_pend & (a[8:5] == regfile_pkg::SEL_GP_HALF);
   assign is_hib  = s.wr_pend & (a[8:4] == regfile_pkg::SEL_GP_HIB);
   assign is_lob  = s.wr_pend & (a[8:4] == regfile_pkg::SEL_GP_LOB);
   assign is_seg  = s.wr_pend & (a[8:5] == regfile_pkg::SEL_SEG)
                    & (a[4:2] < 3'(regfile_pkg::NUM_SEG));
   assign is_fhi  = s.wr_pend & (a[8:7] == regfile_pkg::SEL_FPR)
                    & (a[3:2] == regfile_pkg::FPR_WORD_HI);
   assign is_mm   = s.wr_pend & (a[8:6] == regfile_pkg::SEL_MM);

   // Read handshake: one wait state, then the answer
   sequence s_read_req;
      take && !hwrite;
   endsequence
   sequence s_read_ans;
      !hreadyout ##1 hreadyout;
   endsequence

   // Each write view lands only on its own bits
   a_gp_full_write: assert property (                         // RULE1
      is_full |=> s.gp[$past(a[4:2])] == $past(hwdata))
      else $error("full register write lost");
   a_half_keeps_top: assert property (                        // RULE19
      is_half |=> s.gp[$past(a[4:2])] ==
                  {$past(s.gp[a[4:2]][31:16]), $past(hwdata[15:0])})
      else $error("half write disturbed upper bits");
   a_high_byte_view: assert property (                        // RULE3
      is_hib |=> s.gp[$past(a[3:2])] ==
                 {$past(s.gp[a[3:2]][31:16]), $past(hwdata[7:0]),
                  $past(s.gp[a[3:2]][7:0])})
      else $error("high byte view misplaced");
   a_byte_upper_safe: assert property (                       // RULE4
      is_lob |=> s.gp[7:4] == $past(s.gp[7:4]))
      else $error("byte view reached index register");
   a_seg_width: assert property (                             // RULE5
      is_seg |=> s.seg[$past(a[4:2])] == $past(hwdata[15:0]))
      else $error("segment write wrong");
   // Pointer: read-only on the bus, moved by the pipeline
   a_ip_no_write: assert property (                           // RULE6
      s.wr_pend && a == regfile_pkg::ADDR_IP && !xfer_valid
      && !step_valid && s.op32 |=> s.ip == $past(s.ip))
      else $error("pointer changed by bus write");
   a_ip_transfer: assert property (                           // RULE6
      xfer_valid && next_s.op32 |=> instruction_pointer ==
                                    $past(xfer_target))
      else $error("transfer target not loaded");
   a_float_exp_word: assert property (                        // RULE8
      is_fhi |=> s.fpr[$past(a[6:4])] ==
                 {$past(hwdata[15:0]), $past(s.fpr[a[6:4]][63:0])})
      else $error("sign or exponent word misplaced");
   a_mm_alias_low: assert property (                          // RULE18
      is_mm && !a[2] |=> s.fpr[$past(a[5:3])] ==
         {$past(s.fpr[a[5:3]][79:32]), $past(hwdata)})
      else $error("multimedia alias broken");
   a_read_wait: assert property (
      s_read_req |=> s_read_ans)
      else $error("read answer timing wrong");
   a_low_byte_view: assert property (                         // RULE2
      is_lob |=> s.gp[$past(a[3:2])] ==
                 {$past(s.gp[a[3:2]][31:8]), $past(hwdata[7:0])})
      else $error("low byte view misplaced");
   a_mm_alias_high: assert property (                         // RULE12
      is_mm && a[2] |=> s.fpr[$past(a[5:3])] ==
         {$past(s.fpr[a[5:3]][79:64]), $past(hwdata),
          $past(s.fpr[a[5:3]][31:0])})
      else $error("multimedia high word broken");
   a_mode_write: assert property (                            // RULE6
      s.wr_pend && a == regfile_pkg::ADDR_MODE |=>
         operand_32 == $past(hwdata[0]))
      else $error("operand mode write lost");
   a_ip_step: assert property (                               // RULE6
      step_valid && !xfer_valid && s.op32 && next_s.op32 |=>
         s.ip == $past(s.ip) + {28'h000_0000, $past(step_len)})
      else $error("pointer step wrong");
   a_ip_low_half: assert property (                           // RULE6
      !s.op32 |-> s.ip[31:16] == 16'h0000)
      else $error("pointer left the low half");
   a_rdata_holds: assert property (
      !s.rd_pend |=> $stable(hrdata))
      else $error("read data changed without a read");

endmodule

// ==== pipeline_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Pipeline stand-in driving the IP port
// ----------------------------------------
module pipeline_model (
   input  wire logic        hclk,        // Processor clock
   output logic             xfer_valid,  // Transfer pulse
   output logic      [31:0] xfer_target, // Transfer target
   output logic             step_valid,  // Advance pulse
   output logic      [3:0]  step_len     // Instruction length
);
   // Idle at time zero
   initial begin
      xfer_valid  = 1'b0;
      xfer_target = 32'h0000_0000;
      step_valid  = 1'b0;
      step_len    = 4'h0;
   end

   // One-cycle jump; stale target inverted so it cannot be trusted
   task automatic jump(input logic [31:0] t);
      xfer_valid  <= 1'b1;
      xfer_target <= t;
      @(posedge hclk);
      xfer_valid  <= 1'b0;
      xfer_target <= ~t;
   endtask

   // One-cycle sequential advance
   task automatic step(input logic [3:0] n);
      step_valid <= 1'b1;
      step_len   <= n;
      @(posedge hclk);
      step_valid <= 1'b0;
      step_len   <= ~n;
   endtask
endmodule

// ==== cpu_architectural_register_file_test.sv ====
`timescale 1ns/1ps
module cpu_architectural_register_file_test;
   // ----------------------------------------
   // Bench signals
   // ----------------------------------------
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        xfer_valid;
   logic [31:0] xfer_target;
   logic        step_valid;
   logic [3:0]  step_len;
   logic [31:0] instruction_pointer;
   logic        operand_32;
   logic [31:0] flags_reg;
   logic [31:0] page_directory_control;
   int          fail_count;
   int          n_tests;

   cpu_architectural_register_file i_cpu_architectural_register_file (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .xfer_valid(xfer_valid),
      .xfer_target(xfer_target), .step_valid(step_valid),
      .step_len(step_len), .instruction_pointer(instruction_pointer),
      .operand_32(operand_32), .flags_reg(flags_reg),
      .page_directory_control(page_directory_control));

   pipeline_model i_pipeline_model (
      .hclk(hclk), .xfer_valid(xfer_valid), .xfer_target(xfer_target),
      .step_valid(step_valid), .step_len(step_len));

   // ----------------------------------------
   // Clock and watchdog
   // ----------------------------------------
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // About 250 cycles needed; generous margin
   initial begin
      #100000;
      fail_count = fail_count + 1;
      $display("unexpected timeout expected done seen hang");
      finish_test();
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // Ready sampled at negedge equals its value at the next rising edge
   task automatic bus_wait(output logic [31:0] d);
      logic r;
      r = 1'b0;
      while (r !== 1'b1) begin
         @(negedge hclk);
         r = hreadyout;
         d = hrdata;
         @(posedge hclk);
      end
   endtask

   task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= 1'b1;
      htrans <= 2'b10;
      bus_wait(x);
      htrans <= 2'b00;
      hwdata <= d;
      bus_wait(x);
   endtask

   task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= 1'b0;
      htrans <= 2'b10;
      bus_wait(d);
      htrans <= 2'b00;
      bus_wait(d);
   endtask

   task automatic check(input string n, input logic [31:0] e,
                        input logic [31:0] g);
      n_tests = n_tests + 1;
      if (g !== e) begin
         fail_count = fail_count + 1;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] e,
                         input string n);
      logic [31:0] d;
      bus_read(a, d);
      check(n, e, d);
   endtask

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;  // Word transfers only
      hwdata = 32'h0;
      fail_count = 0;
      n_tests = 0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(32'h000, 32'h0, "gp reset");
      rd_chk(32'h07C, 32'h1, "mode reset");
      check("hresp", 32'h0, {31'h0, hresp});
      for (int i = 0; i < 8; i++) bus_write(32'h0 + 4 * i, 32'hA5A5_0000 + i);
      for (int i = 0; i < 8; i++) rd_chk(4 * i, 32'hA5A5_0000 + i, "gp");
      bus_write(32'h000, 32'h1234_5678);
      bus_write(32'h040, 32'hFFFF_FFAB);
      rd_chk(32'h000, 32'h1234_56AB, "low byte");
      bus_write(32'h050, 32'h0000_00CD);
      rd_chk(32'h000, 32'h1234_CDAB, "high byte");
      rd_chk(32'h020, 32'h0000_CDAB, "half view");
      bus_write(32'h020, 32'hFFFF_BEEF);
      rd_chk(32'h000, 32'h1234_BEEF, "half write");
      bus_write(32'h038, 32'h0000_1111);
      rd_chk(32'h018, 32'hA5A5_1111, "index half");
      for (int i = 0; i < 6; i++) bus_write(32'h60 + 4 * i, 32'hFFFF_0A00 + i);
      for (int i = 0; i < 6; i++) rd_chk(32'h60 + 4 * i, 32'h0A00 + i, "seg");
      for (int i = 0; i < 3; i++) bus_write(32'h84 + 4 * i, 32'hFFFF_F0F1);
      for (int i = 0; i < 3; i++) rd_chk(32'h84 + 4 * i, 32'hF0F1, "fpu w");
      bus_write(32'h080, 32'h0000_0ED5);
      rd_chk(32'h080, 32'h0000_0ED5, "flags");
      check("flags port", 32'h0000_0ED5, flags_reg);
      for (int i = 0; i < 5; i++) bus_write(32'hA0 + 4 * i, 32'hC000_1000 + i);
      for (int i = 0; i < 5; i++) rd_chk(32'hA0 + 4 * i, 32'hC000_1000 + i, "cr");
      check("pdc port", 32'hC000_1003, page_directory_control);
      bus_write(32'h130, 32'h89AB_CDEF);
      bus_write(32'h134, 32'h0123_4567);
      bus_write(32'h138, 32'hFFFF_C003);
      bus_write(32'h13C, 32'h0);
      rd_chk(32'h138, 32'h0000_C003, "sign exp");
      rd_chk(32'h13C, 32'h0, "fpr reserved");
      rd_chk(32'h198, 32'h89AB_CDEF, "mm low");
      rd_chk(32'h19C, 32'h0123_4567, "mm high");
      bus_write(32'h19C, 32'h7654_3210);
      rd_chk(32'h134, 32'h7654_3210, "mm high alias");
      for (int n = 0; n < 8; n++) bus_write(32'h180 + 8 * n, 32'h3C00_0000 + n);
      for (int n = 0; n < 8; n++) rd_chk(32'h100 + 16 * n, 32'h3C00_0000 + n, "alias");
      rd_chk(32'h138, 32'h0000_C003, "exp kept");
      bus_write(32'h090, 32'hFFFF_FFFF);
      rd_chk(32'h090, 32'h0, "unmapped");
      rd_chk(32'h0000_107C, 32'h0, "out of range");
      bus_write(32'h078, 32'hDEAD_0000);
      rd_chk(32'h078, 32'h0, "ip no write");
      i_pipeline_model.jump(32'h1234_5670);
      @(negedge hclk);
      check("ip jump", 32'h1234_5670, instruction_pointer);
      @(posedge hclk);
      i_pipeline_model.step(4'hA);
      @(negedge hclk);
      check("ip step", 32'h1234_567A, instruction_pointer);
      @(posedge hclk);
      rd_chk(32'h078, 32'h1234_567A, "ip read");
      bus_write(32'h07C, 32'h0);
      i_pipeline_model.jump(32'hFFFF_8000);
      repeat (2) @(posedge hclk);
      @(negedge hclk);
      check("mode 16", 32'h0, {31'h0, operand_32});
      check("ip 16", 32'h0000_8000, instruction_pointer);
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(32'h000, 32'h0, "gp rereset");
      rd_chk(32'h07C, 32'h1, "mode rereset");
      finish_test();
   end
endmodule
